// ==== src/clo_cfg.svh ====
// Register offsets, field positions, reset values and limits of the logic operators
`ifndef CLO_CFG_SVH
`define CLO_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CLO_GATE_OFS     8'h00
`define CLO_MACRO_OFS    8'h04
`define CLO_MUX_OFS      8'h08
`define CLO_CMP_OFS      8'h0C
`define CLO_ANA_OFS      8'h10
`define CLO_BLK_OFS      8'h14
`define CLO_STAT_OFS     8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLO_G_OP         0
`define CLO_G_CNT        4
`define CLO_G_INV        8
`define CLO_M_OP1        0
`define CLO_M_OP2        4
`define CLO_M_OP3        8
`define CLO_M_N1         12
`define CLO_M_N2         16
`define CLO_M_DIS        20
`define CLO_M_EN1        21
`define CLO_M_EN2        22
`define CLO_M_INV        24
`define CLO_X_CNT        0
`define CLO_X_DINV       4
`define CLO_X_SINV       8
`define CLO_C_CONST      0
`define CLO_C_NB         8
`define CLO_C_REL        12
`define CLO_C_SIG        15
`define CLO_C_INV        16
`define CLO_A_RAW_EN     0
`define CLO_A_ERR_EN     1
`define CLO_A_NOT_INV    2
`define CLO_S_REFUSED    8
// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define CLO_GATE_RST     32'h0000_0020
`define CLO_MACRO_RST    32'h0001_1000
`define CLO_MUX_RST      32'h0000_0002
`define CLO_CMP_RST      32'h0000_0200
`define CLO_ANA_RST      32'h0000_0000
`define CLO_BLK_RST      8'h00
`define CLO_GATE_WM      32'h0000_FFF7
`define CLO_MACRO_WM     32'hFF77_7777
`define CLO_MUX_WM       32'h0000_0FF7
`define CLO_CMP_WM       32'hFFFF_FFFF
`define CLO_ANA_WM       32'h0000_0007
// ----------------------------------------
// Limits
// ----------------------------------------
`define CLO_BLK_LIM_BAS  8'h40
`define CLO_BLK_LIM_EXT  8'h80
`define CLO_RESP_OKAY    2'h0
`define CLO_RESP_SLVERR  2'h2
`endif

// ==== src/clo_pkg.sv ====
// Types shared by the logic operator block
package clo_pkg;
   typedef enum logic [2:0] {
      OP_AND  = 3'h0,
      OP_NAND = 3'h1,
      OP_OR   = 3'h2,
      OP_NOR  = 3'h3,
      OP_XOR  = 3'h4,
      OP_XNOR = 3'h5,
      OP_SR   = 3'h6
   } clo_op_t;
   typedef enum logic [2:0] {
      REL_LT = 3'h0,
      REL_GE = 3'h1,
      REL_GT = 3'h2,
      REL_LE = 3'h3,
      REL_EQ = 3'h4,
      REL_NE = 3'h5
   } clo_rel_t;
endpackage

// ==== src/clo_operators.sv ====
// Configurable Boolean operators, comparator and analog block outputs with AXI4-Lite setup
//
// Overview of operation
// (RQ1) Raw measurement exposed when analog option enabled
// (RQ2) Error output follows sensor anomaly when enabled
// (RQ3) Each operator input individually invertible
// (RQ4) Block count capped at 64 or 128
// (RQ5) AND is one only when all one
// (RQ6) Gates take two to eight inputs
// (RQ7) NAND is zero only when all one
// (RQ8) Inverter outputs the complement of input
// (RQ9) OR is one when any one
// (RQ10) NOR is zero when any one
// (RQ11) XOR gives odd parity of inputs
// (RQ12) XNOR gives even parity of inputs
// (RQ13) Macro joins two gates into final gate
// (RQ14) First gates take 1..7, one bypasses
// (RQ15) Macro gates selectable, final may be SR
// (RQ16) SR holds, sets, resets; reset wins
// (RQ17) Main output disable, first results optional
// (RQ18) Mux passes input only for one-hot select
// (RQ19) Constant mode compares 2..8 bits to constant
// (RQ20) First input is the least significant bit
// (RQ21) Six relations select comparator output
// (RQ22) Signal mode compares A nibble with B
// (RQ23) Signal mode relations take A against B
// (RQ24) Outputs registered each cycle, zero at reset
`timescale 1ns/10ps
`include "clo_cfg.svh"
module clo_operators #(
   parameter int ADDR_W   = 8,
   parameter bit EXTENDED = 1'b0,
   parameter int RAW_W    = 16
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [7:0]        gate_in,
   input  wire logic              not_in,
   input  wire logic [7:0]        macro_in,
   input  wire logic [3:0]        mux_data,
   input  wire logic [3:0]        mux_select_lines,
   input  wire logic [7:0]        cmp_bits,
   input  wire logic [3:0]        operand_a_bits,
   input  wire logic [3:0]        operand_b_bits,
   input  wire logic [RAW_W-1:0]  analog_raw_in,
   input  wire logic              sensor_anomaly,
   output logic                   gate_out,
   output logic                   not_out,
   output logic                   macro_out,
   output logic                   first_gate_result,
   output logic                   second_gate_result,
   output logic                   mux_out,
   output logic                   cmp_out,
   output logic [RAW_W-1:0]       analog_raw_out,
   output logic                   analog_error_out
);
   import clo_pkg::*;

   localparam logic [7:0] BLK_LIMIT = EXTENDED ? `CLO_BLK_LIM_EXT : `CLO_BLK_LIM_BAS;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [7:0] cnt_mask(input logic [3:0] n);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         m[i] = (4'(i) < n);
      end
      return m;
   endfunction

   function automatic logic [3:0] clamp_n(input logic [3:0] n, input logic [3:0] lo,
                                          input logic [3:0] hi);
      if (n < lo) begin
         return lo;
      end else if (n > hi) begin
         return hi;
      end
      return n;
   endfunction

   // Unused inputs are made neutral so one evaluator serves every width
   function automatic logic gate_eval(input clo_op_t op, input logic [7:0] b,
                                      input logic [3:0] n);
      logic [7:0] m;
      logic       a;
      logic       o;
      logic       x;
      m = cnt_mask(n);
      a = &(b | ~m);
      o = |(b & m);
      x = ^(b & m);
      if (n == 4'h1) begin
         return b[0]; // RQ14
      end
      case (op)
         OP_AND:  return a;  // RQ5
         OP_NAND: return !a; // RQ7
         OP_OR:   return o;  // RQ9
         OP_NOR:  return !o; // RQ10
         OP_XOR:  return x;  // RQ11
         OP_XNOR: return !x; // RQ12
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic rel_eval(input clo_rel_t r, input logic [7:0] a,
                                     input logic [7:0] b);
      case (r)
         REL_LT:  return a < b;
         REL_GE:  return a >= b;
         REL_GT:  return a > b;
         REL_LE:  return a <= b;
         REL_EQ:  return a == b;
         REL_NE:  return a != b;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb, input logic [31:0] wm);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r & wm;
   endfunction

   function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
      return {a[7:2], 2'b00};
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a <= `CLO_STAT_OFS;
   endfunction

   // ----------------------------------------
   // AXI4-Lite write side
   // ----------------------------------------
   logic              aw_held_reg;
   logic [7:0]        awaddr_reg;
   logic              w_held_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              do_wr;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign do_wr         = aw_held_reg && w_held_reg && !bvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 8'h00;
         w_held_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= word_of(s_axi_awaddr);
         end else if (do_wr) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (do_wr) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `CLO_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= mapped(awaddr_reg) ? `CLO_RESP_OKAY : `CLO_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [31:0] gate_cfg_reg;
   logic [31:0] macro_cfg_reg;
   logic [31:0] mux_cfg_reg;
   logic [31:0] cmp_cfg_reg;
   logic [31:0] ana_cfg_reg;
   logic [7:0]  blk_cnt_reg;
   logic        refused_reg;
   logic [31:0] blk_next;

   assign blk_next = merge({24'h00_0000, blk_cnt_reg}, wdata_reg, wstrb_reg, 32'h0000_00FF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_cfg_reg  <= `CLO_GATE_RST;
         macro_cfg_reg <= `CLO_MACRO_RST;
         mux_cfg_reg   <= `CLO_MUX_RST;
         cmp_cfg_reg   <= `CLO_CMP_RST;
         ana_cfg_reg   <= `CLO_ANA_RST;
      end else if (do_wr) begin
         if (awaddr_reg == `CLO_GATE_OFS) begin
            gate_cfg_reg <= merge(gate_cfg_reg, wdata_reg, wstrb_reg, `CLO_GATE_WM);
         end else if (awaddr_reg == `CLO_MACRO_OFS) begin
            macro_cfg_reg <= merge(macro_cfg_reg, wdata_reg, wstrb_reg, `CLO_MACRO_WM);
         end else if (awaddr_reg == `CLO_MUX_OFS) begin
            mux_cfg_reg <= merge(mux_cfg_reg, wdata_reg, wstrb_reg, `CLO_MUX_WM);
         end else if (awaddr_reg == `CLO_CMP_OFS) begin
            cmp_cfg_reg <= merge(cmp_cfg_reg, wdata_reg, wstrb_reg, `CLO_CMP_WM);
         end else if (awaddr_reg == `CLO_ANA_OFS) begin
            ana_cfg_reg <= merge(ana_cfg_reg, wdata_reg, wstrb_reg, `CLO_ANA_WM);
         end
      end
   end

   // Counts over the variant's limit are refused whole, never clipped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blk_cnt_reg <= `CLO_BLK_RST;
         refused_reg <= 1'b0;
      end else if (do_wr && awaddr_reg == `CLO_BLK_OFS) begin
         if (blk_next[7:0] > BLK_LIMIT) begin
            refused_reg <= 1'b1; // RQ4
         end else begin
            blk_cnt_reg <= blk_next[7:0]; // RQ4
            refused_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Operator evaluation
   // ----------------------------------------
   clo_op_t     g_op;
   logic [3:0]  g_n;
   logic [7:0]  g_eff;
   clo_op_t     m_op1;
   clo_op_t     m_op2;
   clo_op_t     m_op3;
   logic [3:0]  m_n1;
   logic [3:0]  m_n2;
   logic [7:0]  m_eff;
   logic        r1;
   logic        r2;
   logic        final_v;
   logic        sr_reg;
   logic [3:0]  x_n;
   logic [3:0]  x_sel;
   logic [3:0]  x_dat;
   logic        x_v;
   clo_rel_t    c_rel;
   logic [7:0]  c_val;
   logic [7:0]  c_a;
   logic [7:0]  c_b;
   logic [3:0]  op_a;
   logic [3:0]  op_b;
   logic        c_v;

   assign g_op  = clo_op_t'(gate_cfg_reg[`CLO_G_OP +: 3]);
   assign g_n   = clamp_n(gate_cfg_reg[`CLO_G_CNT +: 4], 4'h2, 4'h8); // RQ6
   assign g_eff = gate_in ^ gate_cfg_reg[`CLO_G_INV +: 8]; // RQ3

   assign m_op1 = clo_op_t'(macro_cfg_reg[`CLO_M_OP1 +: 3]);
   assign m_op2 = clo_op_t'(macro_cfg_reg[`CLO_M_OP2 +: 3]);
   assign m_op3 = clo_op_t'(macro_cfg_reg[`CLO_M_OP3 +: 3]); // RQ15
   assign m_n1  = clamp_n({1'b0, macro_cfg_reg[`CLO_M_N1 +: 3]}, 4'h1, 4'h7); // RQ14
   // Second gate shrinks so the macro never reads past its eight inputs
   assign m_n2  = clamp_n(clamp_n({1'b0, macro_cfg_reg[`CLO_M_N2 +: 3]}, 4'h1, 4'h7),
                          4'h1, 4'h8 - m_n1); // RQ13
   assign m_eff = macro_in ^ macro_cfg_reg[`CLO_M_INV +: 8]; // RQ3
   assign r1    = gate_eval(m_op1, m_eff, m_n1);
   assign r2    = gate_eval(m_op2, m_eff >> m_n1, m_n2);
   assign final_v = (m_op3 == OP_SR) ? sr_reg : gate_eval(m_op3, {6'h00, r2, r1}, 4'h2); // RQ13

   assign x_n   = clamp_n({1'b0, mux_cfg_reg[`CLO_X_CNT +: 3]}, 4'h2, 4'h4);
   assign x_sel = (mux_select_lines ^ mux_cfg_reg[`CLO_X_SINV +: 4]) & 4'(cnt_mask(x_n));
   assign x_dat = mux_data ^ mux_cfg_reg[`CLO_X_DINV +: 4]; // RQ3
   assign x_v   = $onehot(x_sel) ? |(x_dat & x_sel) : 1'b0; // RQ18

   assign c_rel = clo_rel_t'(cmp_cfg_reg[`CLO_C_REL +: 3]);
   assign c_val = (cmp_bits ^ cmp_cfg_reg[`CLO_C_INV +: 8]) &
                  cnt_mask(clamp_n(cmp_cfg_reg[`CLO_C_NB +: 4], 4'h2, 4'h8)); // RQ19 RQ20
   assign op_a  = operand_a_bits ^ cmp_cfg_reg[`CLO_C_INV + 8 +: 4];
   assign op_b  = operand_b_bits ^ cmp_cfg_reg[`CLO_C_INV + 12 +: 4];
   assign c_a   = cmp_cfg_reg[`CLO_C_SIG] ? {4'h0, op_a} : c_val; // RQ22
   assign c_b   = cmp_cfg_reg[`CLO_C_SIG] ? {4'h0, op_b} : cmp_cfg_reg[`CLO_C_CONST +: 8];
   assign c_v   = rel_eval(c_rel, c_a, c_b); // RQ21 RQ23

   // Reset input of the storage element wins over set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sr_reg <= 1'b0;
      end else if (r2) begin
         sr_reg <= 1'b0; // RQ16
      end else if (r1) begin
         sr_reg <= 1'b1; // RQ16
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_out           <= 1'b0;
         not_out            <= 1'b0;
         macro_out          <= 1'b0;
         first_gate_result  <= 1'b0;
         second_gate_result <= 1'b0;
         mux_out            <= 1'b0;
         cmp_out            <= 1'b0;
         analog_raw_out     <= '0;
         analog_error_out   <= 1'b0;
      end else begin
         gate_out           <= gate_eval(g_op, g_eff, g_n); // RQ24
         not_out            <= !(not_in ^ ana_cfg_reg[`CLO_A_NOT_INV]); // RQ8
         macro_out          <= final_v && !macro_cfg_reg[`CLO_M_DIS]; // RQ17
         first_gate_result  <= r1 && macro_cfg_reg[`CLO_M_EN1]; // RQ17
         second_gate_result <= r2 && macro_cfg_reg[`CLO_M_EN2]; // RQ17
         mux_out            <= x_v;
         cmp_out            <= c_v;
         analog_raw_out     <= ana_cfg_reg[`CLO_A_RAW_EN] ? analog_raw_in : '0; // RQ1
         analog_error_out   <= ana_cfg_reg[`CLO_A_ERR_EN] && sensor_anomaly; // RQ2
      end
   end

   // ----------------------------------------
   // AXI4-Lite read side
   // ----------------------------------------
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rd_word;
   logic [7:0]  ra;

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign ra            = word_of(s_axi_araddr);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (ra == `CLO_GATE_OFS) begin
         rd_word = gate_cfg_reg;
      end else if (ra == `CLO_MACRO_OFS) begin
         rd_word = macro_cfg_reg;
      end else if (ra == `CLO_MUX_OFS) begin
         rd_word = mux_cfg_reg;
      end else if (ra == `CLO_CMP_OFS) begin
         rd_word = cmp_cfg_reg;
      end else if (ra == `CLO_ANA_OFS) begin
         rd_word = ana_cfg_reg;
      end else if (ra == `CLO_BLK_OFS) begin
         rd_word = {24'h00_0000, blk_cnt_reg};
      end else if (ra == `CLO_STAT_OFS) begin
         rd_word = {23'h00_0000, refused_reg, analog_error_out, cmp_out, mux_out,
                    second_gate_result, first_gate_result, macro_out, not_out, gate_out};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `CLO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= mapped(ra) ? `CLO_RESP_OKAY : `CLO_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_and_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
      (g_op == OP_AND) |=> (gate_out == &($past(g_eff) | ~cnt_mask($past(g_n)))))
      else $error("and gate result wrong");
   a_nand_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
      (g_op == OP_NAND && (g_eff & cnt_mask(g_n)) != cnt_mask(g_n)) |=> gate_out)
      else $error("nand gate low with an input low");
   a_or_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
      (g_op == OP_OR) |=> (gate_out == |($past(g_eff) & cnt_mask($past(g_n)))))
      else $error("or gate result wrong");
   a_nor_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
      (g_op == OP_NOR && g_eff[0]) |=> !gate_out)
      else $error("nor gate high with an input high");
   a_xor_parity: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
      (g_op == OP_XOR) |=> (gate_out == ^($past(g_eff) & cnt_mask($past(g_n)))))
      else $error("xor parity wrong");
   a_xnor_parity: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
      (g_op == OP_XNOR && g_n == 4'h2) |=> (gate_out == ($past(g_eff[0]) == $past(g_eff[1]))))
      else $error("xnor parity wrong");
   a_not_invert: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
      $past(aresetn) |-> (not_out != ($past(not_in) ^ $past(ana_cfg_reg[`CLO_A_NOT_INV]))))
      else $error("inverter output wrong");
   a_sr_reset_wins: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
      (r1 && r2) |=> !sr_reg)
      else $error("storage element set while reset high");
   a_mux_none_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
      (!$onehot(x_sel)) |=> !mux_out)
      else $error("mux output high without one-hot select");
   a_cmp_signal_eq: assert property (@(posedge aclk) disable iff (!aresetn) // RQ23
      (cmp_cfg_reg[`CLO_C_SIG] && c_rel == REL_EQ) |=> (cmp_out == ($past(op_a) == $past(op_b))))
      else $error("signal compare equal wrong");
   a_macro_disable: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
      macro_cfg_reg[`CLO_M_DIS] [*2] |-> !macro_out)
      else $error("macro output high while disabled");
   a_error_follow: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
      ana_cfg_reg[`CLO_A_ERR_EN] |=> (analog_error_out == $past(sensor_anomaly)))
      else $error("error output does not follow anomaly");
   a_blk_limit: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
      blk_cnt_reg <= BLK_LIMIT)
      else $error("block count above limit");
endmodule

// ==== tb/clo_operators_tb.sv ====
// Self-checking bench for the configurable logic operator block
`timescale 1ns/10ps
`include "clo_cfg.svh"
module clo_operators_tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, not_in, sensor_anomaly;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, gate_in, macro_in, cmp_bits;
   logic [3:0]  s_axi_wstrb, mux_data, mux_select_lines, operand_a_bits, operand_b_bits;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [15:0] analog_raw_in, analog_raw_out;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        gate_out, not_out, macro_out, first_gate_result, second_gate_result;
   logic        mux_out, cmp_out, analog_error_out;
   int          failures = 0;
   int          checks = 0;
   localparam logic [1:0] OK = `CLO_RESP_OKAY;
   localparam logic [1:0] ER = `CLO_RESP_SLVERR;
   logic [7:0]  gv [4] = '{8'hFE, 8'hFC, 8'h7E, 8'h01};
   logic [7:0]  mm [4] = '{8'h02, 8'h06, 8'h01, 8'h10};
   logic [8:0]  mv [6] = '{9'h144, 9'h0B4, 9'h0F6, 9'h0F0, 9'h188, 9'h111};
   clo_operators DUT (.*);
   always #4 aclk = ~aclk;
   // ----------------------------------------
   // Bus tasks and reference functions
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      bh = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int n = 0; n < 64 && !bh; n++) begin
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         if (bh) chk({30'h0, s_axi_bresp}, {30'h0, er});
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end
      if (!bh) failures++;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic arh, rh;
      rh = 1'b0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int n = 0; n < 64 && !rh; n++) begin
         @(negedge aclk);
         arh = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         if (rh) chk(s_axi_rdata, ed);
         if (rh) chk({30'h0, s_axi_rresp}, {30'h0, er});
         @(posedge aclk);
         if (arh) s_axi_arvalid <= 1'b0;
      end
      if (!rh) failures++;
   endtask
   // Outputs are registered, so two edges pass before the new value is looked at
   task automatic chk_o(input int sel, input logic e);
      logic [7:0] o;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      o = {analog_error_out, cmp_out, mux_out, second_gate_result, first_gate_result,
           macro_out, not_out, gate_out};
      chk({31'h0, o[sel]}, {31'h0, e});
      @(posedge aclk);
   endtask
   function automatic logic gexp(input int op, input logic [7:0] v, input int n);
      logic a, o, x;
      a = 1'b1;
      o = 1'b0;
      x = 1'b0;
      for (int i = 0; i < n; i++) begin
         a &= v[i];
         o |= v[i];
         x ^= v[i];
      end
      return (op < 2) ? a ^ op[0] : (op < 4) ? o ^ op[0] : x ^ op[0];
   endfunction
   function automatic logic rexp(input int r, input int x, input int y);
      return r[0] ^ ((r < 2) ? x < y : (r < 4) ? x > y : x == y);
   endfunction
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
       not_in, sensor_anomaly, s_axi_awaddr, s_axi_araddr, gate_in, macro_in, cmp_bits,
       s_axi_wdata, mux_data, mux_select_lines, operand_a_bits, operand_b_bits,
       analog_raw_in} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_o(0, 1'b0);
      rd(`CLO_GATE_OFS, `CLO_GATE_RST, OK);
      rd(`CLO_MACRO_OFS, `CLO_MACRO_RST, OK);
      rd(8'h1C, 32'h0000_0000, ER);
      wr(8'h1C, 32'hFFFF_FFFF, ER);
      for (int op = 0; op < 6; op++) begin
         for (int n = 2; n < 9; n += 6) begin
            wr(`CLO_GATE_OFS, op | (n << 4) | 32'h0000_0100, OK);
            foreach (gv[i]) begin
               gate_in <= gv[i];
               chk_o(0, gexp(op, gv[i] ^ 8'h01, n));
            end
         end
      end
      wr(`CLO_ANA_OFS, 32'h0000_0007, OK);
      analog_raw_in  <= 16'hA5C3;
      sensor_anomaly <= 1'b1;
      chk_o(1, 1'b0);
      chk({16'h0, analog_raw_out}, 32'h0000_A5C3);
      chk_o(7, 1'b1);
      sensor_anomaly <= 1'b0;
      chk_o(7, 1'b0);
      wr(`CLO_ANA_OFS, 32'h0000_0000, OK);
      chk_o(1, 1'b1);
      chk({16'h0, analog_raw_out}, 32'h0000_0000);
      wr(`CLO_MUX_OFS, 32'h0000_0004, OK);
      foreach (mv[i]) begin
         {mux_data, mux_select_lines} <= mv[i][7:0];
         chk_o(5, mv[i][8]);
      end
      for (int r = 0; r < 6; r++) begin
         for (int k = 0; k < 3; k++) begin
            wr(`CLO_CMP_OFS, 32'h0000_0896 | (r << 12), OK);
            cmp_bits <= 8'(149 + k);
            chk_o(6, rexp(r, 149 + k, 150));
            wr(`CLO_CMP_OFS, 32'h0000_8000 | (r << 12), OK);
            operand_a_bits <= 4'(4 + k);
            operand_b_bits <= 4'h5;
            chk_o(6, rexp(r, 4 + k, 5));
         end
      end
      wr(`CLO_CMP_OFS, 32'h0000_451A, OK);
      cmp_bits <= 8'hFA;
      chk_o(6, 1'b1);
      wr(`CLO_MACRO_OFS, 32'h0163_2420, OK);
      foreach (mm[i]) begin
         macro_in <= mm[i];
         chk_o(3, gexp(0, mm[i] ^ 8'h01, 2));
         chk_o(4, gexp(2, (mm[i] ^ 8'h01) >> 2, 3));
         chk_o(2, gexp(0, mm[i] ^ 8'h01, 2) ^ gexp(2, (mm[i] ^ 8'h01) >> 2, 3));
      end
      wr(`CLO_MACRO_OFS, 32'h0163_2620, OK);
      foreach (gv[i]) begin
         macro_in <= (i == 0) ? 8'h02 : (i == 2) ? 8'h06 : 8'h01;
         chk_o(2, i < 2);
      end
      wr(`CLO_MACRO_OFS, 32'h0113_2420, OK);
      macro_in <= 8'h02;
      chk_o(2, 1'b0);
      chk_o(3, 1'b0);
      wr(`CLO_BLK_OFS, 32'h0000_0040, OK);
      wr(`CLO_BLK_OFS, 32'h0000_0041, OK);
      rd(`CLO_BLK_OFS, 32'h0000_0040, OK);
      rd(`CLO_STAT_OFS, 32'h0000_0163, OK);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      print_verdict();
   end
endmodule
